// ---- rtl/mcd_pkg.sv ----
// Constants and carrier types for the memory command host.
// Assumes one 250 MHz clock that also times the memory command pins.
package mcd_pkg;

  // Widths of the memory side
  localparam int ADDR_W = 22;
  localparam int BANK_W = 3;
  localparam int MODE_W = 18;
  localparam int NBANK = 8;

  // Register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;

  // Command register fields and operation codes
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BANK_LSB = 4;
  localparam logic [2:0] OP_MODE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_RENEW = 3'h4;

  // Status register bits
  localparam int ST_PEND = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_STALE = 2;
  localparam int ST_DLL_WAIT = 3;
  localparam int ST_RECOV = 4;
  localparam int ST_BUSY = 5;

  // Mode word fields
  localparam int MF_CFG_LSB = 0;
  localparam int MF_BL_LSB = 3;
  localparam int MF_MUX_BIT = 5;
  localparam int MF_DLL_BIT = 7;
  localparam logic [17:0] MODE_RST = 18'h0_0000;

  // Burst field codes and latency settings
  localparam logic [1:0] BL_2 = 2'h0;
  localparam logic [1:0] BL_8 = 2'h2;
  localparam logic [1:0] BL_BAD = 2'h3;
  localparam logic [2:0] CFG_MIN = 3'h1;
  localparam logic [2:0] CFG_MAX = 3'h5;
  localparam logic [2:0] CFG_LOW = 3'h1;
  localparam logic [2:0] CFG_SHORT = 3'h4;

  // Row cycle clocks per setting; safe value before any load
  localparam logic [3:0] RC_CFG1 = 4'h4;
  localparam logic [3:0] RC_CFG2 = 4'h6;
  localparam logic [3:0] RC_CFG3 = 4'h8;
  localparam logic [3:0] RC_CFG4 = 4'h3;
  localparam logic [3:0] RC_CFG5 = 4'h5;
  localparam logic [3:0] RC_SAFE = 4'h8;
  localparam logic [3:0] RC_WR4 = 4'h4;

  // Address span for burst 2, and the drop for wider parts
  localparam logic [4:0] AW_BL2 = 5'h16;
  localparam logic [4:0] ORG_DROP = 5'h00;

  // Waits, counted in memory clocks (one per pclk)
  localparam logic [3:0] MLR_CYC = 4'h6;
  localparam int DLL_LOCK_CLK = 1024;
  localparam logic [10:0] DLL_CYC = 11'(DLL_LOCK_CLK);

  // Command pins as one bundle
  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic ref_n;
    logic [ADDR_W-1:0] addr;
    logic [BANK_W-1:0] bank;
  } mcd_pins_t;

  localparam mcd_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, '0, '0};

endpackage : mcd_pkg

// ---- rtl/mcd_host.sv ----
// Command host for an eight-bank burst DRAM: takes orders over APB,
// checks them and drives the memory command pins one command at a time.
// Assumes pclk also clocks the memory, so waits count in pclk cycles.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module mcd_host
  import mcd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory command pins
  output var mcd_pins_t mem_pins
);

  // Row cycle clocks for a latency setting
  function automatic logic [3:0] rc_of(input logic [2:0] cfg);
    case (cfg)
      3'h1: rc_of = RC_CFG1;
      3'h2: rc_of = RC_CFG2;
      3'h3: rc_of = RC_CFG3;
      3'h4: rc_of = RC_CFG4;
      3'h5: rc_of = RC_CFG5;
      default: rc_of = RC_SAFE;
    endcase
  endfunction : rc_of

  // Clocks a burst holds the bus: two beats per clock
  function automatic logic [3:0] beat_clk(input logic [1:0] bl);
    beat_clk = 4'h1 << bl;
  endfunction : beat_clk

  // Address bits usable at a burst length
  function automatic logic [4:0] awidth(input logic [1:0] bl);
    awidth = AW_BL2 - ORG_DROP - {3'h0, bl};
  endfunction : awidth

  // APB answer registers
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Software side state
  logic [ADDR_W-1:0] addr_q; // Staged address
  logic pend_q; // Command waiting to go out
  logic [2:0] pop_q; // Pending operation
  logic [BANK_W-1:0] pbank_q; // Pending bank
  logic [ADDR_W-1:0] pa_q; // Pending address
  logic refused_q; // Sticky: order dropped
  logic stale_q; // Sticky: burst length changed

  // Device view
  logic [MODE_W-1:0] mode_q; // Last mode word sent
  logic mode_ok_q; // A valid mode has been sent
  logic [3:0] bank_cnt_q [NBANK]; // Row cycle left per bank
  logic [4:0] op_cnt_q; // Data burst still on the bus
  logic [3:0] mrsc_cnt_q; // Mode load recovery left
  logic [10:0] dll_cnt_q; // DLL lock wait left
  mcd_pins_t pins_q;

  // Combinational helpers
  logic acc; // Transfer completes this edge
  logic hit; // Address is mapped
  logic [31:0] rd_d;
  logic cmd_wr;
  logic stat_wr;
  logic ok_new;
  logic go;
  logic banks_idle;
  logic [3:0] rc_load;
  mcd_pins_t pins_d;

  // Fields of the live mode and of the staged address
  logic [2:0] cur_cfg;
  logic [1:0] cur_bl;
  logic [2:0] n_cfg;
  logic [1:0] n_bl;

  assign cur_cfg = mode_q[MF_CFG_LSB +: 3];
  assign cur_bl = mode_q[MF_BL_LSB +: 2];
  assign n_cfg = addr_q[MF_CFG_LSB +: 3];
  assign n_bl = addr_q[MF_BL_LSB +: 2];

  // Outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mem_pins = pins_q;

  // One wait state: pready rises in the second access cycle
  assign acc = psel & penable & pready_q;
  assign cmd_wr = acc & pwrite & hit & (paddr == REG_CMD);
  assign stat_wr = acc & pwrite & hit & (paddr == REG_STAT);

  // Register read mux and address decode
  always_comb begin
    rd_d = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == REG_CMD) begin
      rd_d[CMD_OP_LSB +: 3] = pop_q;
      rd_d[CMD_BANK_LSB +: BANK_W] = pbank_q;
    end else if (paddr == REG_ADDR) begin
      rd_d[ADDR_W-1:0] = addr_q;
    end else if (paddr == REG_MODE) begin
      rd_d[MODE_W-1:0] = mode_q;
    end else if (paddr == REG_STAT) begin
      rd_d[ST_PEND] = pend_q;
      rd_d[ST_REFUSED] = refused_q;
      rd_d[ST_STALE] = stale_q;
      rd_d[ST_DLL_WAIT] = (dll_cnt_q != '0);
      rd_d[ST_RECOV] = (mrsc_cnt_q != '0);
      rd_d[ST_BUSY] = (op_cnt_q != '0) | ~banks_idle;
    end else begin
      // Unmapped: error answer, reads zero
      hit = 1'b0;
    end
  end

  // APB answer: pready, read data and error land together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~hit;
      if (psel & penable & ~pready_q) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      end
    end
  end

  // Staged address register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0;
    end else if (acc & pwrite & hit & (paddr == REG_ADDR)) begin
      addr_q <= pwdata[ADDR_W-1:0];
    end
  end

  // Screen a new order; a bad one is dropped rather than sent
  always_comb begin
    ok_new = 1'b0;
    case (pwdata[CMD_OP_LSB +: 3])
      OP_MODE: begin
        // Setting in range, burst code legal, no split address
        ok_new = (n_cfg >= CFG_MIN) && (n_cfg <= CFG_MAX)
          && (n_bl != BL_BAD)
          && !(n_bl == BL_8 && (n_cfg == CFG_LOW
          || n_cfg == CFG_SHORT))
          && !addr_q[MF_MUX_BIT];
      end
      OP_READ, OP_WRITE: begin
        // Needs a known burst length and an address that fits
        ok_new = mode_ok_q
          && ((addr_q >> awidth(cur_bl)) == '0);
      end
      OP_RENEW: begin
        ok_new = 1'b1;
      end
      default: begin
        // Unknown code never reaches the pins
        ok_new = 1'b0;
      end
    endcase
  end

  // Pending command slot; a second order while one waits is refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      pop_q <= '0;
      pbank_q <= '0;
      pa_q <= '0;
    end else if (cmd_wr & ~pend_q & ok_new) begin
      pend_q <= 1'b1;
      pop_q <= pwdata[CMD_OP_LSB +: 3];
      pbank_q <= pwdata[CMD_BANK_LSB +: BANK_W];
      pa_q <= addr_q;
    end else if (go) begin
      pend_q <= 1'b0;
    end
  end

  // Refused flag: write one to clear, a new refusal wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_q <= 1'b0;
    end else if (cmd_wr & (pend_q | ~ok_new)) begin
      refused_q <= 1'b1;
    end else if (stat_wr & pwdata[ST_REFUSED]) begin
      refused_q <= 1'b0;
    end
  end

  // All banks past their row cycle
  always_comb begin
    banks_idle = 1'b1;
    for (int b = 0; b < NBANK; b++) begin
      if (bank_cnt_q[b] != '0) begin
        banks_idle = 1'b0;
      end
    end
  end

  // Decide whether the pending command may go out now
  always_comb begin
    go = 1'b0;
    if (pend_q) begin
      case (pop_q)
        OP_MODE: begin
          // Chained mode loads skip recovery
          go = banks_idle && (op_cnt_q == '0);
        end
        OP_READ: begin
          go = (mrsc_cnt_q == '0)
            && (bank_cnt_q[pbank_q] == '0)
            && (dll_cnt_q == '0);
        end
        default: begin
          go = (mrsc_cnt_q == '0)
            && (bank_cnt_q[pbank_q] == '0);
        end
      endcase
    end
  end

  // Pin pattern for the command going out
  always_comb begin
    pins_d = PINS_IDLE;
    if (go) begin
      pins_d.cs_n = 1'b0;
      case (pop_q)
        OP_MODE: begin
          pins_d.we_n = 1'b0;
          pins_d.ref_n = 1'b0;
          // Upper bits and the unused bit forced low
          pins_d.addr = {4'h0, 8'h00, pa_q[9:7], 1'b0,
            pa_q[5:0]};
        end
        OP_READ: begin
          pins_d.addr = pa_q;
          pins_d.bank = pbank_q;
        end
        OP_WRITE: begin
          pins_d.we_n = 1'b0;
          pins_d.addr = pa_q;
          pins_d.bank = pbank_q;
        end
        default: begin
          // Renew: one bank, address held low
          pins_d.ref_n = 1'b0;
          pins_d.bank = pbank_q;
        end
      endcase
    end
  end

  // Command pins; idle pattern is deselect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= PINS_IDLE;
    end else begin
      pins_q <= pins_d;
    end
  end

  // Mode shadow and stale-data flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RST;
      mode_ok_q <= 1'b0;
    end else if (go && pop_q == OP_MODE) begin
      mode_q <= pins_d.addr[MODE_W-1:0];
      mode_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stale_q <= 1'b0;
    end else if (go && pop_q == OP_MODE && mode_ok_q
        && pa_q[MF_BL_LSB +: 2] != cur_bl) begin
      stale_q <= 1'b1;
    end else if (stat_wr & pwdata[ST_STALE]) begin
      stale_q <= 1'b0;
    end
  end

  // Row cycle to load; the short setting needs one more after a write
  always_comb begin
    rc_load = rc_of(cur_cfg);
    if (pop_q == OP_WRITE && cur_cfg == CFG_SHORT) begin
      rc_load = RC_WR4;
    end
  end

  // Per-bank row cycle counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < NBANK; b++) begin
        bank_cnt_q[b] <= '0;
      end
    end else begin
      for (int b = 0; b < NBANK; b++) begin
        if (go && pop_q != OP_MODE && pbank_q == 3'(b)) begin
          bank_cnt_q[b] <= rc_load;
        end else if (bank_cnt_q[b] != '0) begin
          bank_cnt_q[b] <= bank_cnt_q[b] - 4'h1;
        end
      end
    end
  end

  // Data bus busy: reads and writes alike count latency plus one, then the burst
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_cnt_q <= '0;
    end else if (go && (pop_q == OP_READ || pop_q == OP_WRITE)) begin
      op_cnt_q <= {1'b0, rc_of(cur_cfg)} + 5'h01
        + {1'b0, beat_clk(cur_bl)};
    end else if (op_cnt_q != '0) begin
      op_cnt_q <= op_cnt_q - 5'h01;
    end
  end

  // Mode load recovery
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mrsc_cnt_q <= '0;
    end else if (go && pop_q == OP_MODE) begin
      mrsc_cnt_q <= MLR_CYC;
    end else if (mrsc_cnt_q != '0) begin
      mrsc_cnt_q <= mrsc_cnt_q - 4'h1;
    end
  end

  // DLL lock wait starts when the enable bit rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dll_cnt_q <= '0;
    end else if (go && pop_q == OP_MODE && pa_q[MF_DLL_BIT]
        && !(mode_ok_q && mode_q[MF_DLL_BIT])) begin
      dll_cnt_q <= DLL_CYC;
    end else if (dll_cnt_q != '0) begin
      dll_cnt_q <= dll_cnt_q - 11'h001;
    end
  end

  // Checks on the command stream
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_mode_pins: assert property (
    go && pop_q == OP_MODE |=> !mem_pins.cs_n && !mem_pins.we_n
      && !mem_pins.ref_n)
    else $error("mode load pins wrong");

  chk_read_pins: assert property (
    go && pop_q == OP_READ |=> !mem_pins.cs_n && mem_pins.we_n
      && mem_pins.ref_n && mem_pins.bank == $past(pbank_q))
    else $error("read pins wrong");

  chk_single_cmd: assert property (
    !mem_pins.cs_n |=> mem_pins.cs_n)
    else $error("command held over two cycles");

  chk_renew_addr: assert property (
    !mem_pins.cs_n && mem_pins.we_n && !mem_pins.ref_n
      |-> mem_pins.addr == '0)
    else $error("renew drove an address");

  chk_mode_zero: assert property (
    !mem_pins.cs_n && !mem_pins.we_n && !mem_pins.ref_n
      |-> mem_pins.addr[21:10] == '0 && !mem_pins.addr[6])
    else $error("mode load upper bits not zero");

  // Judged from the pins, so a wrong launch decision is caught too
  chk_mode_idle: assert property (
    !mem_pins.cs_n && !mem_pins.we_n && !mem_pins.ref_n
      |-> $past(banks_idle) && $past(op_cnt_q) == '0)
    else $error("mode load while busy");

  // Six quiet clocks match MLR_CYC; chained mode loads stay legal
  chk_recovery: assert property (
    !mem_pins.cs_n && !mem_pins.we_n && !mem_pins.ref_n
      |=> (mem_pins.cs_n || (!mem_pins.we_n && !mem_pins.ref_n))[*6])
    else $error("command inside mode recovery");

  chk_dll_wait: assert property (
    go && pop_q == OP_READ |-> dll_cnt_q == '0)
    else $error("read during DLL lock wait");

  chk_row_cycle: assert property (
    go && pop_q != OP_MODE |=> bank_cnt_q[mem_pins.bank] >= RC_CFG4)
    else $error("row cycle not loaded");

  chk_cfg4_write: assert property (
    go && pop_q == OP_WRITE && cur_cfg == CFG_SHORT
      |=> bank_cnt_q[mem_pins.bank] == RC_WR4)
    else $error("short setting write spacing wrong");

  chk_bl8_config: assert property (
    !mem_pins.cs_n && !mem_pins.we_n && !mem_pins.ref_n
      && mem_pins.addr[4:3] == BL_8 |-> mem_pins.addr[2:0] != CFG_LOW
      && mem_pins.addr[2:0] != CFG_SHORT)
    else $error("burst eight with short setting");

  chk_addr_width: assert property (
    !mem_pins.cs_n && mem_pins.ref_n
      |-> (mem_pins.addr >> awidth(cur_bl)) == '0)
    else $error("address wider than burst allows");

endmodule : mcd_host

`default_nettype wire

// ---- verif/mcd_mem_model.sv ----
// Behavioural model of the burst memory on the command pins: decodes
// commands, keeps the mode word and counts every timing breach.
// Assumes the pins change only just after rising edges of pclk.
`timescale 1ns/1ps
`default_nettype none

module mcd_mem_model
  import mcd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Command pins from the host
  input wire mcd_pins_t mem_pins,
  // What the model saw
  output int viol,
  output int ncmd,
  output logic [1:0] last_kind,
  output logic [BANK_W-1:0] last_bank,
  output logic [ADDR_W-1:0] last_addr,
  output logic [MODE_W-1:0] mode_q
);
  int cyc; // Clocks since reset
  int last_c [NBANK]; // Clock of the last access per bank
  logic wr4 [NBANK]; // Last access was a write in setting 4
  int mode_c; // Clock of the last mode load
  int dll_c; // Clock the delay loop was switched on
  int rc; // Row cycle of the current setting
  int need; // Row time the addressed bank still asks for
  logic loaded; // A mode word has been taken
  int bus_end; // Clock at which the data bus is free again

  // Row cycle per latency setting; slowest before any load
  always_comb begin
    case (mode_q[2:0])
      3'h1: rc = 4;
      3'h2: rc = 6;
      3'h3: rc = 8;
      3'h4: rc = 3;
      3'h5: rc = 5;
      default: rc = 8;
    endcase
    if (!loaded) begin
      rc = 8;
    end
  end

  // One command per low select; a high select is a no-op
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc = 0;
      viol = 0;
      ncmd = 0;
      mode_q = '0;
      loaded = 1'b0;
      mode_c = -100;
      dll_c = -5000;
      bus_end = 0;
      last_kind = 2'h0;
      last_bank = '0;
      last_addr = '0;
      foreach (last_c[b]) begin
        last_c[b] = -100;
        wr4[b] = 1'b0;
      end
    end else begin
      cyc++;
      if (!mem_pins.cs_n) begin
        ncmd++;
        last_kind = {mem_pins.we_n, mem_pins.ref_n};
        last_bank = mem_pins.bank;
        last_addr = mem_pins.addr;
        if (!mem_pins.we_n && !mem_pins.ref_n) begin
          // Mode load: every bank must be idle, upper bits zero
          foreach (last_c[b]) begin
            if (cyc - last_c[b] < (wr4[b] ? 4 : rc)) viol++;
          end
          // The last burst's data must be off the bus first
          if (cyc < bus_end) viol++;
          if (mem_pins.addr[21:10] != '0 || mem_pins.addr[6]) viol++;
          if (mem_pins.addr[7] && !mode_q[7]) dll_c = cyc;
          mode_q = mem_pins.addr[17:0];
          loaded = 1'b1;
          mode_c = cyc;
        end else begin
          // Bank access: row cycle, recovery, loop lock, width
          need = wr4[mem_pins.bank] ? 4 : rc;
          if (cyc - last_c[mem_pins.bank] < need) viol++;
          if (cyc - mode_c < int'(MLR_CYC)) viol++;
          if (last_kind == 2'b11 && cyc - dll_c < DLL_LOCK_CLK) viol++;
          if (mem_pins.ref_n && (!loaded ||
              (mem_pins.addr >> (22 - mode_q[4:3])) != '0)) viol++;
          last_c[mem_pins.bank] = cyc;
          // Read data ends latency plus burst on; write data a clock later
          if (mem_pins.ref_n) bus_end = cyc + rc + (mem_pins.we_n ? 0 : 1)
            + (1 << mode_q[4:3]);
          wr4[mem_pins.bank] = last_kind == 2'b01 && mode_q[2:0] == 3'h4;
        end
      end
    end
  end

endmodule : mcd_mem_model

`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the memory command host: APB master,
// random command traffic, a memory model watching the pins.
// Assumes the model counts any breach of command spacing.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import mcd_pkg::*;
  logic pclk = 1'b0; // 250 MHz clock
  logic presetn = 1'b0; // Reset, held low at start
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  mcd_pins_t mem_pins;
  int viol;
  int ncmd;
  logic [1:0] last_kind;
  logic [2:0] last_bank;
  logic [21:0] last_addr;
  logic [17:0] mode_q;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] rd; // Data of the last transfer
  logic rerr; // Error flag of the last transfer
  logic [31:0] seed = 32'h0000_0959; // Fixed seed
  // Mode words that must be refused
  localparam logic [21:0] BAD_MODE [7] = '{22'h00_0000, 22'h00_0006,
    22'h00_0007, 22'h00_0019, 22'h00_0011, 22'h00_0014, 22'h00_0022};

  // Clock
  always #2 pclk = ~pclk;

  mcd_host u_mcd_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_pins(mem_pins));

  mcd_mem_model u_mcd_mem_model (.pclk(pclk), .presetn(presetn),
    .mem_pins(mem_pins), .viol(viol), .ncmd(ncmd),
    .last_kind(last_kind), .last_bank(last_bank),
    .last_addr(last_addr), .mode_q(mode_q));

  // Random source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Strobe pattern expected for an operation code
  function automatic logic [1:0] kind(input logic [2:0] op);
    case (op)
      OP_READ: return 2'b11;
      OP_WRITE: return 2'b01;
      OP_RENEW: return 2'b10;
      default: return 2'b00;
    endcase
  endfunction : kind

  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; select stays up so the next setup can follow
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_total++;
      end_of_test();
    end
    rd = prdata;
    rerr = pslverr;
  endtask : apb

  // Send one command and check whether it reached the pins
  task automatic cmd(input logic [2:0] op, input logic [2:0] bk,
                     input logic [21:0] ad, input logic ok);
    int n0;
    int k;
    n0 = ncmd;
    apb(1'b1, REG_ADDR, {10'h000, ad});
    apb(1'b1, REG_CMD, {25'h000_0000, bk, 1'b0, op});
    k = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0000_0000);
      k++;
    end while (rd[ST_PEND] !== 1'b0 && k < 600);
    if (k >= 600) begin
      err_total++;
      end_of_test();
    end
    chk(32'(rd[ST_REFUSED]), 32'(!ok));
    apb(1'b1, REG_STAT, 32'h0000_0002);
    chk(32'(ncmd - n0), 32'(ok));
    if (ok) begin
      chk(32'(last_kind), 32'(kind(op)));
      if (op != OP_MODE) chk(32'(last_bank), 32'(bk));
      if (op == OP_MODE) chk(32'(last_addr), 32'(ad & 22'h00_03BF));
      if (op[2:1] == 2'b01) chk(32'(last_addr), 32'(ad));
    end
  endtask : cmd

  initial begin
    logic [2:0] op;
    logic [1:0] bl;
    logic [1:0] prev_bl;
    logic have;
    logic [21:0] ad;
    logic [31:0] r;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({mem_pins.cs_n, mem_pins.we_n, mem_pins.ref_n}), 32'h7);
    apb(1'b0, REG_MODE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(32'(rerr), 32'h0000_0001);
    cmd(OP_READ, 3'h2, 22'h00_0001, 1'b0);
    for (int i = 0; i < 8; i++) begin
      if (i == 0 || i > 4) cmd(3'(i), 3'h1, 22'h00_0000, 1'b0);
    end
    foreach (BAD_MODE[i]) cmd(OP_MODE, 3'h0, BAD_MODE[i], 1'b0);
    $display("Test refusals done");
    have = 1'b0;
    prev_bl = 2'h0;
    for (int c = 1; c <= 5; c++) begin
      for (int b = 0; b < 3; b++) begin
        bl = 2'(b);
        if (bl == BL_8 && (c == 1 || c == 4)) continue;
        r = rnd();
        ad = {r[21:6], 1'b0, bl, 3'(c)};
        cmd(OP_MODE, r[24:22], ad, 1'b1);
        apb(1'b0, REG_MODE, 32'h0000_0000);
        chk(rd, {22'h00_0000, ad[9:7], 1'b0, ad[5:0]});
        chk(32'(rerr), 32'h0000_0000);
        apb(1'b0, REG_STAT, 32'h0000_0000);
        chk(32'(rd[ST_STALE]), 32'(have && bl != prev_bl));
        apb(1'b1, REG_STAT, 32'h0000_0004);
        have = 1'b1;
        prev_bl = bl;
        if (bl != BL_2) cmd(OP_WRITE, 3'h1, 22'(1) << (22 - b), 1'b0);
        repeat (8) begin
          r = rnd();
          op = (r[1:0] == 2'h0) ? OP_RENEW : (r[0] ? OP_READ : OP_WRITE);
          cmd(op, r[5:3], r[31:10] >> bl, 1'b1);
        end
        $display("Test setting %0d burst code %0d done", c, bl);
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(32'(viol), 32'h0000_0000);
    end_of_test();
  end

endmodule : testbench

`default_nettype wire
